// file: rtl/lcl_pkg.sv
/*
 * Package for the line clock watch and register select block.
 * Assumes a 10 MHz core clock; all timing counts are derived from it.
 */
package lcl_pkg;
	localparam int unsigned CORE_CLK_HZ = 10000000;
	localparam int unsigned CLK_PERIOD_NS = 100;

	// Clock watch timeout, longest time, rounded down
	localparam int unsigned WATCH_TIMEOUT_MS = 500;
	localparam int unsigned WATCH_CYCLES = (WATCH_TIMEOUT_MS * (CORE_CLK_HZ / 1000));
	localparam int unsigned WATCH_W = 23;

	// Receive loss report pulse, 75 ns, at least one cycle
	localparam int unsigned LOSS_PULSE_NS = 75;
	localparam int unsigned LOSS_PULSE_CYCLES =
		(LOSS_PULSE_NS < CLK_PERIOD_NS) ? 1 : (LOSS_PULSE_NS / CLK_PERIOD_NS);

	// Indirect write pulse, 100 ns
	localparam int unsigned WRITE_PULSE_NS = 100;
	localparam int unsigned WRITE_PULSE_CYCLES =
		(WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PULSE_W = 4;

	// Error and pointer register fields
	localparam int unsigned ERR_TX_LOSS_BIT = 0;
	localparam int unsigned ERR_RX_LOSS_BIT = 1;
	localparam int unsigned PTR_LSB = 8;
	localparam int unsigned PTR_MSB = 11;
	localparam int unsigned EXT_WEN_BIT = 12;
	localparam logic [15:0] ERR_PTR_RESET = 16'h0000;

	// Pointer codes decoded locally
	localparam logic [3:0] PTR_PATTERN = 4'h9;
	localparam logic [3:0] PTR_AUX = 4'ha;
endpackage : lcl_pkg

// file: rtl/lcl_clock_watch.sv
/*
 * Retriggerable clock loss watchdog for one line clock.
 * Assumes lineClk is already synchronised to core_clk.
 */
`timescale 1ns/1ps
module lcl_clock_watch #(
	parameter int unsigned TIMEOUT = lcl_pkg::WATCH_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic lineClkSync,
	input wire logic armed,
	output logic expired,
	output logic running
);
	typedef struct packed {
		logic [lcl_pkg::WATCH_W-1:0] count;
		logic lastClk;
		logic seen;
	} lcl_watch_t;

	lcl_watch_t st_ff;
	lcl_watch_t nxt_st;
	logic risingEdge;

	assign risingEdge = lineClkSync & ~st_ff.lastClk;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.lastClk = lineClkSync;
		if (risingEdge) begin
			nxt_st.count = lcl_pkg::WATCH_W'(TIMEOUT);
			nxt_st.seen = 1'b1;
		end else if (st_ff.count != '0) begin
			nxt_st.count = st_ff.count - 1'b1;
		end
		if (st_ff.count == '0 && !risingEdge)
			nxt_st.seen = 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign expired = armed & (st_ff.count == '0);
	assign running = st_ff.seen;

	a_edge_reload: assert property (@(posedge core_clk) disable iff (!resetn)
		risingEdge |=> (st_ff.count == lcl_pkg::WATCH_W'(TIMEOUT)))
		else $error("watch not reloaded on line clock edge");
endmodule : lcl_clock_watch

// file: rtl/lcl_line_clock_loss.sv
/*
 * Line clock loss detection, receive fallback control, error/pointer
 * register and indirect register write strobes.
 * Assumes host strobes are core_clk synchronous; line clocks are async.
 */
`timescale 1ns/1ps
module lcl_line_clock_loss #(
	parameter int unsigned WATCH_TIMEOUT = lcl_pkg::WATCH_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic txLineClk,
	input wire logic rxLineClk,
	input wire logic txRun,
	input wire logic rxRun,
	input wire logic testLoop,
	input wire logic rx_transfer_done,
	input wire logic count_address_update_cycle,
	input wire logic outHigh,
	input wire logic outLow,
	input wire logic selErrPtr,
	input wire logic selIndirect,
	input wire logic [15:0] writeData,
	output logic [15:0] errPtrRead,
	output logic txErr,
	output logic rxErr,
	output logic rx_fallback_shift_flag,
	output logic load_pointer_byte,
	output logic load_error_byte,
	output logic load_aux_control,
	output logic load_pattern_register,
	output logic load_count_address_memory,
	output logic load_extension_bits,
	output logic indirect_load_export
);
	typedef struct packed {
		logic [1:0] txSync;
		logic [1:0] rxSync;
		logic [15:0] errPtr;
		logic fallback;
		logic [lcl_pkg::PULSE_W-1:0] lossCnt;
		logic [lcl_pkg::PULSE_W-1:0] wrCnt;
		logic lastCycle;
		logic armPending;
		logic extHold;
		logic lastTxRun;
		logic txErr;
		logic rxErr;
		logic lastTxLoss;
		logic lastRxExp;
	} lcl_state_t;

	lcl_state_t st_ff;
	lcl_state_t nxt_st;

	logic txExpired;
	logic txRunning;
	logic rxExpired;
	logic rxRunning;
	logic txArmed;
	logic rxArmed;
	logic txLoss;
	logic rxLossPulse;
	logic writePulse;
	logic decodeEnable;
	logic [3:0] pointer;

	assign pointer = st_ff.errPtr[lcl_pkg::PTR_MSB:lcl_pkg::PTR_LSB];
	assign txArmed = txRun & ~testLoop;
	assign rxArmed = rxRun & ~testLoop;

	lcl_clock_watch #(
		.TIMEOUT(WATCH_TIMEOUT)
	) u_tx_clock_watch_timer (
		.core_clk(core_clk),
		.resetn(resetn),
		.lineClkSync(st_ff.txSync[1]),
		.armed(txArmed),
		.expired(txExpired),
		.running(txRunning)
	);

	lcl_clock_watch #(
		.TIMEOUT(WATCH_TIMEOUT)
	) u_rx_clock_watch_timer (
		.core_clk(core_clk),
		.resetn(resetn),
		.lineClkSync(st_ff.rxSync[1]),
		.armed(rxArmed),
		.expired(rxExpired),
		.running(rxRunning)
	);

	assign txLoss = txExpired | (txArmed & ~st_ff.lastTxRun & ~txRunning);
	assign rxLossPulse = (st_ff.lossCnt != '0) & rxRun;
	assign writePulse = st_ff.wrCnt != '0;
	// Decoder enabled by pointer bit 11
	assign decodeEnable = writePulse & pointer[3];

	always_comb begin
		nxt_st = st_ff;
		nxt_st.txSync = {st_ff.txSync[0], txLineClk};
		nxt_st.rxSync = {st_ff.rxSync[0], rxLineClk};
		nxt_st.lastTxRun = txArmed;
		nxt_st.lastCycle = count_address_update_cycle;
		nxt_st.lastTxLoss = txLoss;
		nxt_st.lastRxExp = rxExpired;

		if (selErrPtr && outLow)
			nxt_st.errPtr[7:0] = writeData[7:0];
		if (selErrPtr && outHigh)
			nxt_st.errPtr[15:8] = writeData[15:8];

		// Arm on select write, fire on cycle rise
		if (selIndirect && outLow)
			nxt_st.armPending = 1'b1;
		if (st_ff.armPending && count_address_update_cycle && !st_ff.lastCycle) begin
			nxt_st.armPending = 1'b0;
			nxt_st.wrCnt = lcl_pkg::PULSE_W'(lcl_pkg::WRITE_PULSE_CYCLES);
		end else if (writePulse) begin
			nxt_st.wrCnt = st_ff.wrCnt - 1'b1;
		end

		if (writePulse)
			nxt_st.errPtr[lcl_pkg::EXT_WEN_BIT] = 1'b0;
		if (selErrPtr && outHigh)
			nxt_st.errPtr[lcl_pkg::EXT_WEN_BIT] = writeData[lcl_pkg::EXT_WEN_BIT];

		// Hold flag ends at pulse trailing edge
		if (writePulse && st_ff.wrCnt == lcl_pkg::PULSE_W'(1))
			nxt_st.extHold = 1'b0;
		else if (st_ff.errPtr[lcl_pkg::EXT_WEN_BIT])
			nxt_st.extHold = 1'b1;

		// Expiry edge sets fallback, so done is not undone
		if (rxExpired && rxArmed && !st_ff.lastRxExp)
			nxt_st.fallback = 1'b1;
		if (rx_transfer_done)
			nxt_st.fallback = 1'b0;

		if (st_ff.fallback && !nxt_st.fallback)
			nxt_st.lossCnt = lcl_pkg::PULSE_W'(lcl_pkg::LOSS_PULSE_CYCLES);
		else if (st_ff.lossCnt != '0)
			nxt_st.lossCnt = st_ff.lossCnt - 1'b1;

		// Tx loss sets bit 0, set beats clear
		nxt_st.txErr = txLoss & ~st_ff.lastTxLoss;
		if (txLoss)
			nxt_st.errPtr[lcl_pkg::ERR_TX_LOSS_BIT] = 1'b1;
		nxt_st.rxErr = rxLossPulse;
		if (rxLossPulse)
			nxt_st.errPtr[lcl_pkg::ERR_RX_LOSS_BIT] = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			st_ff <= '0;
			st_ff.errPtr <= lcl_pkg::ERR_PTR_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign errPtrRead = st_ff.errPtr;
	assign txErr = st_ff.txErr;
	assign rxErr = st_ff.rxErr;
	assign rx_fallback_shift_flag = st_ff.fallback;
	assign load_pointer_byte = selErrPtr & outHigh;
	assign load_error_byte = selErrPtr & outLow;
	assign load_pattern_register = decodeEnable & (pointer == lcl_pkg::PTR_PATTERN);
	assign load_aux_control = decodeEnable & (pointer == lcl_pkg::PTR_AUX);
	assign indirect_load_export = decodeEnable;
	// Count/address write when bit 11 clear
	assign load_count_address_memory = writePulse & ~pointer[3];
	assign load_extension_bits = load_count_address_memory &
		(st_ff.extHold | st_ff.errPtr[lcl_pkg::EXT_WEN_BIT]);

	a_tx_loss_flag: assert property (@(posedge core_clk) disable iff (!resetn)
		(txLoss && !st_ff.lastTxLoss) |=> (st_ff.errPtr[0] && txErr))
		else $error("tx loss did not set bit 0");

	a_tx_err_single: assert property (@(posedge core_clk) disable iff (!resetn)
		txErr |=> !txErr)
		else $error("tx error pulse longer than one cycle");

	a_tx_err_bit: assert property (@(posedge core_clk) disable iff (!resetn)
		txErr |-> errPtrRead[lcl_pkg::ERR_TX_LOSS_BIT])
		else $error("tx error without loss bit");

	a_tx_timeout: assert property (@(posedge core_clk) disable iff (!resetn)
		txExpired |=> errPtrRead[0])
		else $error("tx timeout did not set bit 0");

	a_tx_run_dead: assert property (@(posedge core_clk) disable iff (!resetn)
		(txArmed && !st_ff.lastTxRun && !txRunning) |=> errPtrRead[0])
		else $error("tx run without clock not flagged");

	a_test_mode_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
		testLoop |-> (!txLoss && !(rxExpired && rxArmed)))
		else $error("detector active in test mode");

	a_tx_test_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
		$past(testLoop) |-> !txErr)
		else $error("tx error raised in test mode");

	a_rx_test_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
		(testLoop && !rx_fallback_shift_flag) |=> !rx_fallback_shift_flag)
		else $error("fallback set in test mode");

	a_fallback_set: assert property (@(posedge core_clk) disable iff (!resetn)
		(rxExpired && rxArmed && !st_ff.lastRxExp && !rx_transfer_done)
		|=> rx_fallback_shift_flag)
		else $error("fallback not set on rx timeout");

	a_fallback_clear: assert property (@(posedge core_clk) disable iff (!resetn)
		rx_transfer_done |=> !rx_fallback_shift_flag)
		else $error("fallback not cleared by done");

	a_rx_loss_report: assert property (@(posedge core_clk) disable iff (!resetn)
		($fell(rx_fallback_shift_flag) && rxRun) |=> (rxErr && errPtrRead[1]))
		else $error("rx loss not reported");

	a_rx_err_gated: assert property (@(posedge core_clk) disable iff (!resetn)
		rxErr |-> $past(rxRun))
		else $error("rx loss reported without rx run");

	a_rx_err_single: assert property (@(posedge core_clk) disable iff (!resetn)
		rxErr |=> !rxErr)
		else $error("rx error pulse longer than one cycle");

	a_err_bytes: assert property (@(posedge core_clk) disable iff (!resetn)
		(selErrPtr && outHigh && outLow) |-> (load_pointer_byte && load_error_byte))
		else $error("word write missing a byte load");

	a_ptr_load: assert property (@(posedge core_clk) disable iff (!resetn)
		(selErrPtr && outHigh) |=> (errPtrRead[11:8] == $past(writeData[11:8])))
		else $error("pointer not loaded by high byte");

	a_low_load: assert property (@(posedge core_clk) disable iff (!resetn)
		(selErrPtr && outLow) |=> (errPtrRead[7:2] == $past(writeData[7:2])))
		else $error("low byte not loaded");

	a_ptr_stable: assert property (@(posedge core_clk) disable iff (!resetn)
		!(selErrPtr && outHigh) |=> $stable(errPtrRead[11:8]))
		else $error("pointer changed without a write");

	a_decode_only: assert property (@(posedge core_clk) disable iff (!resetn)
		(load_aux_control || load_pattern_register) |-> (pointer[3] && writePulse))
		else $error("decode strobe without enable");

	a_aux_decode: assert property (@(posedge core_clk) disable iff (!resetn)
		(writePulse && errPtrRead[11:8] == lcl_pkg::PTR_AUX)
		|-> (load_aux_control && !load_pattern_register))
		else $error("aux control strobe missing");

	a_pattern_decode: assert property (@(posedge core_clk) disable iff (!resetn)
		(writePulse && errPtrRead[11:8] == lcl_pkg::PTR_PATTERN)
		|-> (load_pattern_register && !load_aux_control))
		else $error("pattern register strobe missing");

	a_export_enable: assert property (@(posedge core_clk) disable iff (!resetn)
		indirect_load_export |-> (writePulse && errPtrRead[11]))
		else $error("export strobe without enable");

	a_ca_strobe: assert property (@(posedge core_clk) disable iff (!resetn)
		(writePulse && !errPtrRead[11]) |-> (load_count_address_memory && !indirect_load_export))
		else $error("count/address strobe missing");

	a_pulse_width: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(writePulse) |-> writePulse ##1 !writePulse)
		else $error("indirect write pulse not one cycle");

	a_pulse_fire: assert property (@(posedge core_clk) disable iff (!resetn)
		(st_ff.armPending && count_address_update_cycle && !st_ff.lastCycle) |=> writePulse)
		else $error("armed write did not fire");

	a_no_fire: assert property (@(posedge core_clk) disable iff (!resetn)
		(!st_ff.armPending && !writePulse) |=> !writePulse)
		else $error("write pulse without arming");

	a_ext_single: assert property (@(posedge core_clk) disable iff (!resetn)
		(writePulse && !(selErrPtr && outHigh)) |=> !errPtrRead[12])
		else $error("extension enable not cleared");

	a_ext_strobe: assert property (@(posedge core_clk) disable iff (!resetn)
		(errPtrRead[12] && !pointer[3] && writePulse) |-> load_extension_bits)
		else $error("extension strobe missing");

	a_ext_hold_end: assert property (@(posedge core_clk) disable iff (!resetn)
		($fell(writePulse) && !errPtrRead[12]) |-> !st_ff.extHold)
		else $error("extension hold outlived the write pulse");
endmodule : lcl_line_clock_loss

// file: sim/lcl_far_side.sv
/* Far side model: the modem's transmit and receive line clocks.
   Assumes the bench gates each clock with an enable. */
`timescale 1ns/1ps
module lcl_far_side (
	input wire logic txOn,
	input wire logic rxOn,
	output logic txLineClk,
	output logic rxLineClk
);
	initial begin
		txLineClk = 1'b0;
		forever #400 txLineClk = txOn ? ~txLineClk : 1'b0;
	end
	initial begin
		rxLineClk = 1'b0;
		forever #400 rxLineClk = rxOn ? ~rxLineClk : 1'b0;
	end
endmodule : lcl_far_side

// file: sim/tb_top.sv
/* Bench for the line clock loss block: host writes, loss and strobes.
   Assumes the far side model supplies both line clocks. */
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic txOn = 1'b0;
	logic rxOn = 1'b0;
	logic txLineClk, rxLineClk, txErr, rxErr, fallback;
	logic txRun = 1'b0, rxRun = 1'b0, testLoop = 1'b0, rxDone = 1'b0, updCycle = 1'b0;
	logic outHigh = 1'b0, outLow = 1'b0, selErrPtr = 1'b0, selIndirect = 1'b0;
	logic [15:0] writeData = 16'h0000;
	logic [15:0] errPtrRead;
	logic ldPtr, ldErr, ldAux, ldPat, ldCa, ldExt, ldExp;
	int n_fail = 0;
	int num_checks = 0;

	always #50 core_clk = ~core_clk;

	lcl_far_side far (.txOn(txOn), .rxOn(rxOn), .txLineClk(txLineClk), .rxLineClk(rxLineClk));

	// Short watch timeout so expiry fits in the run
	lcl_line_clock_loss #(.WATCH_TIMEOUT(50)) uut (.core_clk(core_clk), .resetn(resetn),
		.txLineClk(txLineClk),
		.rxLineClk(rxLineClk), .txRun(txRun), .rxRun(rxRun), .testLoop(testLoop),
		.rx_transfer_done(rxDone), .count_address_update_cycle(updCycle),
		.outHigh(outHigh), .outLow(outLow), .selErrPtr(selErrPtr),
		.selIndirect(selIndirect), .writeData(writeData), .errPtrRead(errPtrRead),
		.txErr(txErr), .rxErr(rxErr), .rx_fallback_shift_flag(fallback),
		.load_pointer_byte(ldPtr), .load_error_byte(ldErr), .load_aux_control(ldAux),
		.load_pattern_register(ldPat), .load_count_address_memory(ldCa),
		.load_extension_bits(ldExt), .indirect_load_export(ldExp));

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic reg_write(input logic hi, input logic lo, input logic [15:0] d);
		@(negedge core_clk);
		selErrPtr = 1'b1;
		outHigh = hi;
		outLow = lo;
		writeData = d;
		@(negedge core_clk);
		selErrPtr = 1'b0;
		outHigh = 1'b0;
		outLow = 1'b0;
		@(negedge core_clk);
	endtask : reg_write

	// Counts loss pulses; the receive side must stay quiet throughout
	task automatic watch_tx(input logic [15:0] expHits, input logic expBit);
		logic [15:0] hits;
		logic [15:0] rxHits;
		hits = 16'h0000;
		rxHits = 16'h0000;
		repeat (4) begin
			@(negedge core_clk);
			hits = hits + {15'h0000, txErr};
			rxHits = rxHits + {15'h0000, rxErr | fallback};
		end
		check("txErr pulses", expHits, hits);
		check("tx loss bit", {15'h0000, expBit}, {15'h0000, errPtrRead[0]});
		check("rx quiet", 16'h0000, rxHits);
		txRun = 1'b0;
		testLoop = 1'b0;
	endtask : watch_tx

	task automatic test_regs();
		reg_write(1'b1, 1'b1, 16'h0300);
		check("word write", 16'h0300, errPtrRead & 16'h1f03);
		reg_write(1'b1, 1'b0, 16'h09ff);
		check("high byte", 16'h0900, errPtrRead & 16'h1f03);
		reg_write(1'b0, 1'b1, 16'h0a00);
		check("low byte", 16'h0900, errPtrRead & 16'h1f03);
		$display("done regs");
	endtask : test_regs

	task automatic test_tx_loss();
		logic [15:0] hits;
		hits = 16'h0000;
		testLoop = 1'b1;
		txRun = 1'b1;
		watch_tx(16'h0000, 1'b0);
		@(negedge core_clk);
		txRun = 1'b1;
		watch_tx(16'h0001, 1'b1);
		reg_write(1'b1, 1'b1, 16'h0000);
		check("clear loss", 16'h0000, errPtrRead & 16'h1f03);
		txOn = 1'b1;
		repeat (40) @(negedge core_clk);
		txRun = 1'b1;
		repeat (100) @(negedge core_clk);
		watch_tx(16'h0000, 1'b0);
		txRun = 1'b1;
		txOn = 1'b0;
		repeat (80) begin
			@(negedge core_clk);
			hits = hits + {15'h0000, txErr};
		end
		check("tx timeout pulses", 16'h0001, hits);
		check("tx timeout bit", 16'h0001, {15'h0000, errPtrRead[0]});
		txRun = 1'b0;
		$display("done tx loss");
	endtask : test_tx_loss

	// Strobe order: pattern, aux, count/address, extension, export
	task automatic indirect(input logic [3:0] ptr, input logic ext, input logic arm,
		input logic [4:0] exp);
		logic [4:0] seen;
		logic [15:0] width;
		seen = 5'h00;
		width = 16'h0000;
		reg_write(1'b1, 1'b0, {3'h0, ext, ptr, 8'h00});
		check("ext enable set", {15'h0000, ext}, {15'h0000, errPtrRead[12]});
		selIndirect = arm;
		outLow = arm;
		outHigh = arm;
		@(negedge core_clk);
		selIndirect = 1'b0;
		outLow = 1'b0;
		outHigh = 1'b0;
		updCycle = 1'b1;
		repeat (4) begin
			@(negedge core_clk);
			seen = seen | {ldPat, ldAux, ldCa, ldExt, ldExp};
			width = width + {15'h0000, |{ldPat, ldAux, ldCa, ldExt, ldExp}};
		end
		updCycle = 1'b0;
		check("strobes", {11'h000, exp}, {11'h000, seen});
		check("pulse width", {15'h0000, |exp}, width);
		check("ext enable cleared", {15'h0000, ext & ~arm}, {15'h0000, errPtrRead[12]});
	endtask : indirect

	task automatic test_indirect();
		indirect(4'h9, 1'b0, 1'b1, 5'b10001);
		indirect(4'ha, 1'b0, 1'b1, 5'b01001);
		indirect(4'h8, 1'b0, 1'b1, 5'b00001);
		indirect(4'h3, 1'b0, 1'b1, 5'b00100);
		indirect(4'h5, 1'b1, 1'b1, 5'b00110);
		indirect(4'h3, 1'b0, 1'b1, 5'b00100);
		indirect(4'h9, 1'b0, 1'b0, 5'b00000);
		$display("done indirect");
	endtask : test_indirect

	task automatic test_rx_loss();
		logic [15:0] hits;
		hits = 16'h0000;
		rxOn = 1'b1;
		repeat (40) @(negedge core_clk);
		rxRun = 1'b1;
		repeat (100) @(negedge core_clk);
		check("fallback idle", 16'h0000, {15'h0000, fallback});
		rxOn = 1'b0;
		repeat (80) @(negedge core_clk);
		check("fallback set", 16'h0001, {15'h0000, fallback});
		rxDone = 1'b1;
		@(negedge core_clk);
		rxDone = 1'b0;
		repeat (4) begin
			@(negedge core_clk);
			hits = hits + {15'h0000, rxErr};
		end
		check("fallback cleared", 16'h0000, {15'h0000, fallback});
		check("rxErr pulses", 16'h0001, hits);
		check("rx loss bit", 16'h0001, {15'h0000, errPtrRead[1]});
		rxRun = 1'b0;
		@(negedge core_clk);
		rxRun = 1'b1;
		repeat (4) @(negedge core_clk);
		check("fallback again", 16'h0001, {15'h0000, fallback});
		rxRun = 1'b0;
		rxDone = 1'b1;
		@(negedge core_clk);
		rxDone = 1'b0;
		repeat (4) begin
			@(negedge core_clk);
			hits = hits + {15'h0000, rxErr};
		end
		check("rx report gated", 16'h0001, hits);
		$display("done rx loss");
	endtask : test_rx_loss

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	initial begin
		repeat (5) @(negedge core_clk);
		resetn = 1'b1;
		repeat (3) @(negedge core_clk);
		check("reset value", 16'h0000, errPtrRead);
		test_regs();
		test_tx_loss();
		test_indirect();
		test_rx_loss();
		end_sim();
	end

	// Scenarios need well under a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		end_sim();
	end
endmodule : tb_top
